// *** bhc_pkg.sv ***
// shared types and constants of the bus release and halt control block
// assumes one 250 MHz system clock and a core sequencer on the same clock
`default_nettype none

package bhc_pkg;

    // system clock and processor cycle timing
    localparam int BHC_SYS_CLK_MHZ = 250;
    localparam int BHC_CPU_CYCLE_NS = 1000;
    localparam int BHC_CYC_CLKS = BHC_CPU_CYCLE_NS * BHC_SYS_CLK_MHZ / 1000;
    localparam logic [7:0] BHC_CYC_LAST = 8'(BHC_CYC_CLKS - 1);
    localparam logic [7:0] BHC_PH1_LAST = 8'(BHC_CYC_CLKS / 2 - 1);
    localparam logic [7:0] BHC_PH2_FIRST = 8'(BHC_CYC_CLKS / 2 + 1);
    localparam logic [7:0] BHC_PH2_LAST = 8'(BHC_CYC_CLKS - 2);

    // restart vector locations
    localparam logic [15:0] BHC_VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] BHC_VEC_LO_ADDR = 16'hFFFF;

    typedef enum logic [2:0] {
        BHC_ST_RESET,
        BHC_ST_VEC_HI,
        BHC_ST_VEC_LO,
        BHC_ST_RUN,
        BHC_ST_HALTED
    } bhc_state_e;

    // pin side drive of the system bus
    typedef struct packed {
        logic [15:0] addr;
        logic addr_oe;
        logic rw;
        logic rw_oe;
        logic [7:0] data;
        logic data_oe;
        logic address_valid_strobe;
        logic bus_available;
    } bhc_bus_s;

    // access the core sequencer asks for in the current cycle
    typedef struct packed {
        logic [15:0] addr;
        logic rw;
        logic valid_access;
        logic [7:0] wdata;
        logic last_cycle;
    } bhc_core_req_s;

    localparam bhc_bus_s BHC_BUS_RESET = '{
        addr: BHC_VEC_HI_ADDR, addr_oe: 1'b1, rw: 1'b1, rw_oe: 1'b1,
        data: 8'h00, data_oe: 1'b0, address_valid_strobe: 1'b0,
        bus_available: 1'b0};

endpackage

`default_nettype wire

// *** bhc_bus_control.sv ***
// bus release, halt, single step and restart control of the processor
// assumes pins arrive asynchronous; core request and acks on sys_clk
`default_nettype none

module bhc_bus_control
    import bhc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic bus_float_request,
    input wire logic halt_n,
    input wire logic cpu_reset_n,
    input wire logic nmi_n,
    input wire logic irq_n,
    input wire logic data_drive_enable,
    input wire logic [7:0] data_in,
    input wire bhc_core_req_s core_req,
    input wire logic nmi_ack,
    input wire logic irq_ack,
    output bhc_bus_s bus_out,
    output logic phase1,
    output logic phase2,
    output logic cycle_step,
    output logic nmi_pending,
    output logic irq_pending,
    output logic [15:0] start_vector,
    output logic start_vector_valid
);

    typedef struct packed {
        bhc_state_e st;
        logic [7:0] div;
        logic [1:0] float_ff;
        logic [1:0] halt_ff;
        logic [1:0] rst_ff;
        logic [1:0] nmi_ff;
        logic [1:0] irq_ff;
        logic [1:0] dde_ff;
        logic [7:0] din_ff1;
        logic [7:0] din_ff2;
        logic float_prev;
        logic nmi_prev;
        logic halt_take;
        logic dead;
        logic nmi_pend;
        logic irq_pend;
        logic step;
        logic ph1;
        logic ph2;
        logic [15:0] vec;
        logic vec_valid;
        bhc_bus_s bus;
    } bhc_regs_s;

    localparam bhc_regs_s BHC_REGS_RESET = '{
        st: BHC_ST_RESET, div: 8'h00, float_ff: 2'h0, halt_ff: 2'h3,
        rst_ff: 2'h0, nmi_ff: 2'h3, irq_ff: 2'h3, dde_ff: 2'h0,
        din_ff1: 8'h00, din_ff2: 8'h00, float_prev: 1'b0, nmi_prev: 1'b1,
        halt_take: 1'b0, dead: 1'b0, nmi_pend: 1'b0, irq_pend: 1'b0,
        step: 1'b0, ph1: 1'b1, ph2: 1'b0, vec: 16'h0000,
        vec_valid: 1'b0, bus: BHC_BUS_RESET};

    bhc_regs_s q;
    bhc_regs_s d;

    logic fl;
    logic halt_hi;
    logic boundary;
    logic ph1_trail;
    logic nmi_edge;

    always_comb begin
        d = q;
        d.step = 1'b0;
        d.vec_valid = 1'b0;
        // two-stage synchronisers on every pin
        d.float_ff = {q.float_ff[0], bus_float_request};
        d.halt_ff = {q.halt_ff[0], halt_n};
        d.rst_ff = {q.rst_ff[0], cpu_reset_n};
        d.nmi_ff = {q.nmi_ff[0], nmi_n};
        d.irq_ff = {q.irq_ff[0], irq_n};
        d.dde_ff = {q.dde_ff[0], data_drive_enable};
        d.din_ff1 = data_in;
        d.din_ff2 = q.din_ff1;
        fl = q.float_ff[1];
        halt_hi = q.halt_ff[1];
        boundary = (q.div == BHC_CYC_LAST);
        ph1_trail = (q.div == BHC_PH1_LAST);
        nmi_edge = q.nmi_prev && !q.nmi_ff[1];
        d.nmi_prev = q.nmi_ff[1];
        d.float_prev = fl;

        // phase enables, gaps between them keep them apart
        d.div = boundary ? 8'h00 : q.div + 8'h01;
        d.ph1 = (d.div <= BHC_PH1_LAST);
        d.ph2 = (d.div >= BHC_PH2_FIRST) && (d.div <= BHC_PH2_LAST);

        // interrupt latches, a new event beats the acknowledge
        d.nmi_pend = nmi_edge || (q.nmi_pend && !nmi_ack);
        d.irq_pend = !q.irq_ff[1] ||
            (q.irq_pend && q.st == BHC_ST_HALTED && !irq_ack);

        // float release leaves one dead cycle
        if (q.float_prev && !fl) begin
            d.dead = 1'b1;
        end

        // halt decision at the trailing edge of phase one
        if (ph1_trail && !fl) begin
            if (q.st == BHC_ST_HALTED) begin
                d.halt_take = !halt_hi;
            end else if (q.st == BHC_ST_RUN && core_req.last_cycle) begin
                d.halt_take = !halt_hi;
            end
        end

        if (boundary) begin
            if (!q.rst_ff[1]) begin
                d.st = BHC_ST_RESET;
                d.dead = 1'b0;
                d.halt_take = 1'b0;
            end else if (!fl) begin
                unique case (q.st)
                    BHC_ST_RESET: begin
                        d.st = BHC_ST_VEC_HI;
                    end
                    BHC_ST_VEC_HI: begin
                        d.vec[15:8] = q.din_ff2;
                        d.st = BHC_ST_VEC_LO;
                    end
                    BHC_ST_VEC_LO: begin
                        d.vec[7:0] = q.din_ff2;
                        d.vec_valid = 1'b1;
                        d.st = BHC_ST_RUN;
                    end
                    BHC_ST_RUN: begin
                        if (q.dead) begin
                            d.dead = 1'b0;
                        end else begin
                            d.step = 1'b1;
                            if (q.halt_take) begin
                                d.st = BHC_ST_HALTED;
                            end
                        end
                    end
                    BHC_ST_HALTED: begin
                        d.dead = 1'b0;
                        if (!q.halt_take) begin
                            d.st = BHC_ST_RUN;
                        end
                    end
                endcase
            end
        end

        // bus drive from the state now being entered
        d.bus = BHC_BUS_RESET;
        d.bus.addr_oe = !fl && d.st != BHC_ST_HALTED;
        d.bus.rw_oe = !fl && d.st != BHC_ST_HALTED;
        d.bus.bus_available = !fl && d.st == BHC_ST_HALTED;
        unique case (d.st)
            BHC_ST_RESET: begin
                d.bus.addr = BHC_VEC_HI_ADDR;
            end
            BHC_ST_VEC_HI: begin
                d.bus.addr = BHC_VEC_HI_ADDR;
                d.bus.address_valid_strobe = !fl;
            end
            BHC_ST_VEC_LO: begin
                d.bus.addr = BHC_VEC_LO_ADDR;
                d.bus.address_valid_strobe = !fl;
            end
            BHC_ST_RUN: begin
                d.bus.addr = core_req.addr;
                d.bus.rw = core_req.rw;
                d.bus.data = core_req.wdata;
                d.bus.address_valid_strobe =
                    core_req.valid_access && !fl && !d.dead;
                d.bus.data_oe = q.dde_ff[1] && core_req.valid_access &&
                    !core_req.rw && !fl && !d.dead;
            end
            BHC_ST_HALTED: begin
                d.bus.addr = core_req.addr;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q <= BHC_REGS_RESET;
        end else begin
            q <= d;
        end
    end

    assign bus_out = q.bus;
    assign phase1 = q.ph1;
    assign phase2 = q.ph2;
    assign cycle_step = q.step;
    assign nmi_pending = q.nmi_pend;
    assign irq_pending = q.irq_pend;
    assign start_vector = q.vec;
    assign start_vector_valid = q.vec_valid;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    chk_float_release_pins: assert property (
        q.float_ff[1] |=> !q.bus.addr_oe && !q.bus.rw_oe)
        else $error("bus not floated during float request");
    chk_float_strobe_low: assert property (
        q.float_ff[1] |=> !q.bus.address_valid_strobe && !q.bus.bus_available)
        else $error("strobe or bus released high during float");
    chk_float_halted_ba: assert property (
        q.float_ff[1] && q.st == BHC_ST_HALTED |=> !q.bus.bus_available)
        else $error("bus released high while floated and halted");
    chk_dead_cycle_skip: assert property (
        q.dead && q.st == BHC_ST_RUN && q.rst_ff[1] && !q.float_ff[1] &&
        q.div == BHC_CYC_LAST |=> !q.step && !q.dead ##1 !q.step)
        else $error("dead cycle after float release advanced the core");
    chk_strobe_has_addr: assert property (
        q.bus.address_valid_strobe |-> q.bus.addr_oe)
        else $error("strobe high without a driven address");
    chk_halt_last_only: assert property (
        $rose(q.halt_take) && q.st == BHC_ST_RUN |->
        $past(core_req.last_cycle) && $past(q.div) == BHC_PH1_LAST)
        else $error("halt taken outside last cycle phase one end");
    chk_halt_enter_ba: assert property (
        q.st == BHC_ST_RUN && q.halt_take && !q.dead && q.rst_ff[1] &&
        !q.float_ff[1] && q.div == BHC_CYC_LAST |=>
        q.st == BHC_ST_HALTED && q.bus.bus_available)
        else $error("halt not entered at instruction end");
    chk_released_bus_off: assert property (
        q.bus.bus_available |-> !q.bus.addr_oe && !q.bus.data_oe &&
        !q.bus.rw_oe && !q.bus.address_valid_strobe)
        else $error("bus driven while released");
    chk_halt_irq_latch: assert property (
        q.st == BHC_ST_HALTED && !q.irq_ff[1] |=> q.irq_pend [*2])
        else $error("interrupt not latched while halted");
    chk_reset_outputs: assert property (
        !q.rst_ff[1] && !q.float_ff[1] && q.div == BHC_CYC_LAST |=>
        q.bus.addr == BHC_VEC_HI_ADDR && q.bus.rw && !q.bus.data_oe &&
        !q.bus.address_valid_strobe && !q.bus.bus_available)
        else $error("wrong outputs while reset held");
    chk_vector_fetch: assert property (
        q.st == BHC_ST_VEC_LO && q.rst_ff[1] && !q.float_ff[1] &&
        q.div == BHC_CYC_LAST |=> q.vec_valid && q.st == BHC_ST_RUN)
        else $error("start vector not delivered after low byte");
    chk_data_needs_dde: assert property (
        q.bus.data_oe |-> $past(q.dde_ff[1]))
        else $error("data driven without data drive enable");
    chk_phases_apart: assert property (
        !(q.ph1 && q.ph2) and (q.div == BHC_CYC_LAST |=> q.ph1))
        else $error("phase enables overlap or misplaced");

    cov_float_window: cover property (
        $rose(q.float_ff[1]) ##[1:1000] $fell(q.float_ff[1]));
    cov_halt_entry: cover property ($rose(q.bus.bus_available));
    cov_single_step: cover property (
        q.st == BHC_ST_HALTED ##1 q.st == BHC_ST_RUN ##[1:1000]
        q.st == BHC_ST_HALTED);
    cov_restart: cover property (q.vec_valid);

endmodule

`default_nettype wire

// *** bhc_master_model.sv ***
// partner model: bus master sharing the system bus, with vector memory
// assumes the bench commands it; it moves float and halt only in the phase windows, data on every clock
`default_nettype none
module bhc_master_model
    import bhc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic phase1,
    input wire logic phase2,
    input wire bhc_bus_s bus_out,
    input wire logic float_cmd,
    input wire logic halt_cmd,
    input wire logic late,
    input wire logic [15:0] vec,
    output logic bus_float_request,
    output logic halt_n,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bus_float_request = 1'b0;
        halt_n = 1'b1;
        data_in = 8'h00;
    end
    always @(negedge sys_clk) begin
        if (phase1 && !phase2) begin
            bus_float_request <= float_cmd;
            if (!late) begin
                halt_n <= !halt_cmd;
            end
        end
        // deliberately late halt change, in phase two
        if (late && phase2) begin
            halt_n <= !halt_cmd;
        end
        if (bus_out.addr_oe && bus_out.rw && bus_out.address_valid_strobe) begin
            data_in <= bus_out.addr[0] ? vec[7:0] : vec[15:8];
        end else begin
            // undriven data bus: keep changing
            data_in <= ~data_in;
        end
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// testbench of the bus release and halt control block
// assumes the master model beside it and a small core model in here
`default_nettype none
module tb
    import bhc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cpu_reset_n = 1'b0;
    logic nmi_n = 1'b1;
    logic irq_n = 1'b1;
    logic dde = 1'b0;
    logic nmi_ack = 1'b0;
    logic irq_ack = 1'b0;
    logic float_cmd = 1'b0;
    logic halt_cmd = 1'b0;
    logic late = 1'b0;
    logic [15:0] vec = 16'h0000;
    bhc_core_req_s core_req = '0;
    bhc_bus_s bus_out;
    logic phase1, phase2, cycle_step, start_vector_valid;
    logic nmi_pending, irq_pending, float_req, halt_n;
    logic [15:0] start_vector;
    logic [7:0] data_in;
    logic [31:0] seed = 32'h0000000B;
    logic [15:0] exp_q[$];
    int miscompares = 0;
    int num_checks = 0;
    int cnt = 0;
    int ilen = 2;
    int low_n = 0;
    int t;
    always #2 sys_clk = ~sys_clk;
    bhc_bus_control bhc_bus_control_i (.sys_clk(sys_clk), .nrst(nrst),
        .bus_float_request(float_req), .halt_n(halt_n), .nmi_n(nmi_n),
        .cpu_reset_n(cpu_reset_n), .irq_n(irq_n), .data_in(data_in),
        .data_drive_enable(dde), .core_req(core_req), .nmi_ack(nmi_ack),
        .irq_ack(irq_ack), .bus_out(bus_out), .phase1(phase1),
        .phase2(phase2), .cycle_step(cycle_step), .start_vector(start_vector),
        .nmi_pending(nmi_pending), .irq_pending(irq_pending),
        .start_vector_valid(start_vector_valid));
    bhc_master_model bhc_master_model_i (.sys_clk(sys_clk), .phase1(phase1),
        .phase2(phase2), .bus_out(bus_out), .float_cmd(float_cmd),
        .halt_cmd(halt_cmd), .late(late), .vec(vec), .halt_n(halt_n),
        .bus_float_request(float_req), .data_in(data_in));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] ctl();
        return 16'({bus_out.addr_oe, bus_out.rw_oe, bus_out.data_oe,
            bus_out.address_valid_strobe, bus_out.bus_available});
    endfunction
    function automatic logic cond(input int k);
        case (k)
            0: return bus_out.bus_available;
            1: return !bus_out.bus_available;
            2: return cycle_step;
            3: return float_req;
            4: return !float_req;
            5: return core_req.last_cycle && phase2;
            6: return cnt == 0 && phase1;
            7: return start_vector_valid;
            default: return phase2;
        endcase
    endfunction
    task automatic final_report();
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_on(input int k, output int n);
        n = 0;
        while (n < 2000 && cond(k) !== 1'b1) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 2000) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic restart();
        int n;
        vec = 16'(rnd());
        exp_q.push_back(vec);
        cpu_reset_n = 1'b1;
        wait_on(7, n);
        @(negedge sys_clk);
        chk(16'(exp_q.size()), 16'h0000);
    endtask
    task automatic halt_at(input logic lt, input int expn);
        int n;
        int w;
        // let the core model take the step first
        @(negedge sys_clk);
        wait_on(lt ? 5 : 6, w);
        late = lt;
        halt_cmd = 1'b1;
        n = 0;
        w = 0;
        while (bus_out.bus_available !== 1'b1 && w < 2000) begin
            @(negedge sys_clk);
            n += int'(cycle_step === 1'b1);
            w++;
        end
        late = 1'b0;
        if (w == 2000) begin
            miscompares++;
            final_report();
        end
        chk(16'(n), 16'(expn));
        chk(ctl(), 16'h0001);
    endtask
    // core model: instructions of ilen cycles, next request after each step
    always @(negedge sys_clk) begin
        low_n += int'(bus_out.bus_available === 1'b0);
        if (cycle_step === 1'b1) begin
            cnt = core_req.last_cycle ? 0 : cnt + 1;
            {core_req.addr, core_req.wdata, core_req.rw,
                core_req.valid_access} = 26'(rnd());
            core_req.last_cycle = cnt == ilen - 1;
        end
        if (start_vector_valid === 1'b1) begin
            chk(start_vector, exp_q.size() > 0 ? exp_q.pop_front() : ~vec);
        end
    end
    initial begin
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (2) begin
            repeat (600) @(negedge sys_clk);
            chk(bus_out.addr, BHC_VEC_HI_ADDR);
            chk(ctl(), 16'h0018);
            chk(16'(bus_out.rw), 16'h0001);
            halt_cmd = 1'b0;
            restart();
            repeat (8) begin
                wait_on(2, t);
                dde = rnd() > 32'h7FFFFFFF;
                repeat (100) @(negedge sys_clk);
                chk(bus_out.addr, core_req.addr);
                chk(ctl(), 16'({2'b11, !core_req.rw && dde &&
                    core_req.valid_access, core_req.valid_access, 1'b0}));
                chk(16'(bus_out.data), 16'(core_req.wdata));
                chk(16'({phase1, phase2}), 16'h0002);
            end
            dde = 1'b0;
            wait_on(2, t);
            float_cmd = 1'b1;
            wait_on(3, t);
            repeat (4) @(negedge sys_clk);
            chk(ctl(), 16'h0000);
            t = 0;
            repeat (500) @(negedge sys_clk) t += int'(cycle_step === 1'b1);
            chk(16'(t), 16'h0000);
            float_cmd = 1'b0;
            wait_on(4, t);
            repeat (4) @(negedge sys_clk);
            chk(ctl(), 16'h0018);
            wait_on(2, t);
            chk(16'(t > 246), 16'h0001);
            ilen = 2;
            halt_at(1'b0, ilen);
            halt_cmd = 1'b0;
            wait_on(1, t);
            halt_at(1'b1, ilen + 1);
            nmi_n = 1'b0;
            irq_n = 1'b0;
            wait_on(8, t);
            float_cmd = 1'b1;
            wait_on(3, t);
            repeat (4) @(negedge sys_clk);
            chk(ctl(), 16'h0000);
            chk(16'({nmi_pending, irq_pending}), 16'h0003);
            float_cmd = 1'b0;
            repeat (600) @(negedge sys_clk);
            chk(ctl(), 16'h0001);
            for (int l = 2; l < 4; l++) begin
                ilen = l;
                @(posedge sys_clk);
                low_n = 0;
                @(negedge sys_clk);
                halt_cmd = 1'b0;
                repeat (250) @(negedge sys_clk);
                halt_cmd = 1'b1;
                wait_on(1, t);
                chk(16'({nmi_pending, irq_pending}), 16'h0003);
                wait_on(0, t);
                chk(16'(low_n), 16'(250 * l));
            end
            nmi_n = 1'b1;
            irq_n = 1'b1;
            repeat (10) @(negedge sys_clk);
            nmi_ack = 1'b1;
            irq_ack = 1'b1;
            @(negedge sys_clk);
            nmi_ack = 1'b0;
            irq_ack = 1'b0;
            repeat (10) @(negedge sys_clk);
            chk(16'({nmi_pending, irq_pending}), 16'h0000);
            cpu_reset_n = 1'b0;
        end
        final_report();
    end
endmodule
`default_nettype wire
